// *** logic/hub_boot_params.svh ***
`ifndef HUB_BOOT_PARAMS_SVH
`define HUB_BOOT_PARAMS_SVH

// Clock and timing
`define HB_CLK_PERIOD_NS 25
`define HB_STRAP_SETTLE_NS 1000
`define HB_STRAP_SETTLE_CYC ((`HB_STRAP_SETTLE_NS + `HB_CLK_PERIOD_NS - 1) / `HB_CLK_PERIOD_NS)
`define HB_SPI_HALF_CYC 8

// Serial ROM signature probe
`define HB_ROM_READ_CMD 8'h03
`define HB_ROM_SIG_ADDR 24'hFFFA
`define HB_ROM_EXEC_ADDR 24'h0000
`define HB_ROM_SIG_WORD 32'h32444655
`define HB_ROM_SHIFT_BITS 7'h40
`define HB_ROM_OUT_BITS 7'h20

// Six-level resistor strap codes
`define HB_LVL_200K_PD 3'h0
`define HB_LVL_200K_PU 3'h1
`define HB_LVL_10K_PD 3'h2
`define HB_LVL_10K_PU 3'h3
`define HB_LVL_10R_PD 3'h4
`define HB_LVL_10R_PU 3'h5

// Port masks per level
`define HB_MASK_NONE 6'h00
`define HB_MASK_P1 6'h01
`define HB_MASK_P12 6'h03
`define HB_MASK_P123 6'h07
`define HB_MASK_P1234 6'h0F
`define HB_MASK_ALL 6'h3F

// Register byte addresses
`define HB_REG_STATUS 12'h000
`define HB_REG_STRAPS 12'h004
`define HB_REG_GP_DIR 12'h008
`define HB_REG_GP_OUT 12'h00C
`define HB_REG_GP_PULL_EN 12'h010
`define HB_REG_GP_PULL_UP 12'h014
`define HB_REG_GP_IN 12'h018
`define HB_REG_CFG_END_IDX 12'h0FF
`define HB_REG_CFG_END (`HB_REG_CFG_END_IDX << 2)

// Bus responses
`define HB_RESP_OKAY 2'h0
`define HB_RESP_SLVERR 2'h2

`endif

// *** logic/hub_boot_pkg.sv ***
package hub_boot_pkg;
  typedef enum logic [2:0] {
    st_init,
    st_rom_check,
    st_cfg_read,
    st_strap,
    st_host_cfg,
    st_final,
    st_ready
  } boot_state_t;
endpackage : hub_boot_pkg

// *** logic/rom_job_if.sv ***
`timescale 1ns/100ps
// Request and answer between the boot sequencer and the serial ROM probe
interface rom_job_if;
  logic start;
  logic clock_mode3;
  logic done;
  logic match;
  modport seq (output start, output clock_mode3, input done, input match);
  modport eng (input start, input clock_mode3, output done, output match);
endinterface : rom_job_if

// *** logic/rom_signature_probe.sv ***
`timescale 1ns/100ps
`include "hub_boot_params.svh"
module rom_signature_probe (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Job port
  rom_job_if.eng job,
  // Serial ROM pins, miso already synchronised
  input wire logic rom_miso_sync,
  output logic rom_sclk,
  output logic rom_cs_n,
  output logic rom_mosi
);
  localparam logic [31:0] OUT_WORD = {`HB_ROM_READ_CMD, `HB_ROM_SIG_ADDR};
  // Mid point of the first low phase, where mode 3 makes its lead-in fall
  localparam logic [3:0] MID = 4'(`HB_SPI_HALF_CYC / 2);

  logic [3:0] div;
  logic tick;
  logic active;
  logic phase_high;
  logic mode3;
  logic [6:0] bitcnt;
  logic [31:0] out_sr;
  logic [31:0] in_sr;
  logic last_bit;

  assign tick = (div == 4'(`HB_SPI_HALF_CYC - 1));
  assign last_bit = (bitcnt == `HB_ROM_SHIFT_BITS - 7'h01);

  // Half-period divider, enable pulse only while a job runs
  always_ff @(posedge aclk) begin
    if (!aresetn || !active || tick) div <= 4'h0;
    else div <= div + 4'h1;
  end

  // Read command, address, then 32 data bits; shift on falling, sample before it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= 1'b0;
      phase_high <= 1'b0;
      mode3 <= 1'b0;
      bitcnt <= 7'h00;
      out_sr <= 32'h0;
      in_sr <= 32'h0;
      rom_cs_n <= 1'b1;
      rom_sclk <= 1'b0;
      rom_mosi <= 1'b0;
      job.done <= 1'b0;
      job.match <= 1'b0;
    end else begin
      job.done <= 1'b0;
      if (!active && job.start) begin
        active <= 1'b1;
        mode3 <= job.clock_mode3;
        rom_sclk <= job.clock_mode3; // Idle level per clock mode
        rom_cs_n <= 1'b0;
        phase_high <= 1'b0;
        bitcnt <= 7'h00;
        rom_mosi <= OUT_WORD[31];
        out_sr <= {OUT_WORD[30:0], 1'b0};
      end else if (active && tick) begin
        if (!phase_high) begin
          phase_high <= 1'b1;
          rom_sclk <= 1'b1; // Sampling edge in both modes
        end else begin
          phase_high <= 1'b0;
          in_sr <= {in_sr[30:0], rom_miso_sync};
          bitcnt <= bitcnt + 7'h01;
          if (last_bit) begin
            active <= 1'b0;
            rom_cs_n <= 1'b1;
            rom_sclk <= mode3;
            job.done <= 1'b1;
            job.match <= ({in_sr[30:0], rom_miso_sync} == `HB_ROM_SIG_WORD);
          end else begin
            rom_sclk <= 1'b0;
            rom_mosi <= out_sr[31];
            out_sr <= {out_sr[30:0], 1'b0};
          end
        end
      end else if (active && !phase_high && div == MID) begin
        rom_sclk <= 1'b0; // Lead-in falling edge for mode 3
      end else if (!active) begin
        rom_sclk <= job.clock_mode3; // Idle level follows the strap between frames
      end
    end
  end
endmodule : rom_signature_probe

// *** logic/strap_decoder.sv ***
`timescale 1ns/100ps
`include "hub_boot_params.svh"
module strap_decoder (
  // Synchronised strap levels
  input wire logic [5:0] plus_disable,
  input wire logic [5:0] minus_disable,
  input wire logic [2:0] fixed_level,
  input wire logic [2:0] charge_level,
  // Decoded masks
  output logic [5:0] port_off,
  output logic [5:0] fixed_mask,
  output logic [5:0] charge_mask
);
  // Six resistor levels to a leading-ports mask; unknown codes select none
  function automatic logic [5:0] level_to_mask(input logic [2:0] lvl);
    case (lvl)
      `HB_LVL_200K_PD: level_to_mask = `HB_MASK_NONE;
      `HB_LVL_200K_PU: level_to_mask = `HB_MASK_P1;
      `HB_LVL_10K_PD: level_to_mask = `HB_MASK_P12;
      `HB_LVL_10K_PU: level_to_mask = `HB_MASK_P123;
      `HB_LVL_10R_PD: level_to_mask = `HB_MASK_P1234;
      `HB_LVL_10R_PU: level_to_mask = `HB_MASK_ALL;
      default: level_to_mask = `HB_MASK_NONE;
    endcase
  endfunction : level_to_mask

  // A line reads 1 as disabled; the port goes off only with both lines off
  assign port_off = plus_disable & minus_disable;
  assign fixed_mask = level_to_mask(fixed_level);
  assign charge_mask = level_to_mask(charge_level);
endmodule : strap_decoder

// *** logic/hub_boot_strap_sequencer.sv ***
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "hub_boot_params.svh"
module hub_boot_strap_sequencer
  import hub_boot_pkg::*;
#(
  parameter int GP_W = 8,
  parameter logic [5:0] DEFAULT_FIXED = `HB_MASK_NONE,
  parameter logic [5:0] DEFAULT_CHARGE = `HB_MASK_NONE
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Strap and detect pins
  input wire logic rom_mode_strap,
  input wire logic rom_clock_mode3,
  input wire logic [2:0] slave_bus_setting,
  input wire logic mgmt_bus_data_pin,
  input wire logic mgmt_bus_clock_pin,
  input wire logic [5:0] port_plus_line_disable,
  input wire logic [5:0] port_minus_line_disable,
  input wire logic [2:0] fixed_port_select_strap,
  input wire logic [2:0] charge_port_select_strap,
  input wire logic pll_locked,
  // Serial ROM
  input wire logic rom_miso,
  output logic rom_sclk,
  output logic rom_cs_n,
  output logic rom_mosi,
  output logic rom_pins_oe,
  // General-purpose pins
  input wire logic [GP_W-1:0] general_purpose_pin_in,
  output logic [GP_W-1:0] general_purpose_pin_out,
  output logic [GP_W-1:0] general_purpose_pin_oe,
  output logic [GP_W-1:0] gp_pull_up_en,
  output logic [GP_W-1:0] gp_pull_down_en,
  // Hub status
  output logic pll_run,
  output logic ext_rom_enable,
  output logic [23:0] exec_start_addr,
  output logic host_cfg_active,
  output logic config_done,
  output logic [5:0] port_enable,
  output logic [5:0] ss_port_enable,
  output logic [5:0] fixed_port_mask,
  output logic [5:0] charge_port_mask
);
  localparam int SYNC_W = 27 + GP_W;
  localparam int SETTLE = `HB_STRAP_SETTLE_CYC;

  // Three-flop synchronisers; a bit moves once stages two and three agree
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] pins;
  assign pins_raw = {general_purpose_pin_in, rom_miso, pll_locked, rom_clock_mode3,
                     rom_mode_strap, mgmt_bus_clock_pin, mgmt_bus_data_pin,
                     charge_port_select_strap, fixed_port_select_strap,
                     slave_bus_setting, port_minus_line_disable, port_plus_line_disable};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pins[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) pins[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // Named fields of the filtered pins
  wire [5:0] s_plus = pins[5:0];
  wire [5:0] s_minus = pins[11:6];
  wire [2:0] s_cfg = pins[14:12];
  wire [2:0] s_fixed = pins[17:15];
  wire [2:0] s_charge = pins[20:18];
  wire s_mdata = pins[21];
  wire s_mclk = pins[22];
  wire s_rom_mode = pins[23];
  wire s_mode3 = pins[24];
  wire s_lock = pins[25];
  wire s_miso = pins[26];
  wire [GP_W-1:0] s_gp_in = pins[SYNC_W-1:27];

  // Strap decoding and ROM probe
  logic [5:0] dec_off;
  logic [5:0] dec_fixed;
  logic [5:0] dec_charge;
  strap_decoder u_dec (
    .plus_disable(s_plus),
    .minus_disable(s_minus),
    .fixed_level(s_fixed),
    .charge_level(s_charge),
    .port_off(dec_off),
    .fixed_mask(dec_fixed),
    .charge_mask(dec_charge)
  );

  rom_job_if job ();
  rom_signature_probe u_probe (
    .aclk(aclk),
    .aresetn(aresetn),
    .job(job),
    .rom_miso_sync(s_miso),
    .rom_sclk(rom_sclk),
    .rom_cs_n(rom_cs_n),
    .rom_mosi(rom_mosi)
  );

  // Boot state and latched straps
  boot_state_t state;
  boot_state_t next_state;
  logic [5:0] off_latched;
  logic [5:0] settle_cnt;
  logic start_q;
  logic cfg_end_hit;
  wire settled = (settle_cnt == 6'(SETTLE - 1));
  wire slave_sel = (s_cfg == `HB_LVL_200K_PU);
  wire pullups_seen = s_mdata & s_mclk;
  wire enumerated = (state == st_host_cfg) || (state == st_ready);

  assign job.start = start_q;
  assign job.clock_mode3 = s_mode3;

  // Stage transitions
  always_comb begin
    next_state = state;
    case (state)
      st_init: if (s_lock) next_state = s_rom_mode ? st_rom_check : st_cfg_read;
      st_rom_check: if (job.done) next_state = st_cfg_read;
      st_cfg_read: if (settled) next_state = st_strap;
      st_strap: next_state = (slave_sel && pullups_seen) ? st_host_cfg : st_final;
      st_host_cfg: if (cfg_end_hit) next_state = st_final;
      st_final: next_state = st_ready;
      st_ready: next_state = st_ready;
      default: next_state = st_init;
    endcase
  end

  // Sequencer registers; synchronous reset is standby and clears all but the port masks, which load DEFAULT_FIXED and DEFAULT_CHARGE
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_init;
      start_q <= 1'b0;
      settle_cnt <= 6'h00;
      pll_run <= 1'b0;
      rom_pins_oe <= 1'b0;
      ext_rom_enable <= 1'b0;
      exec_start_addr <= `HB_ROM_EXEC_ADDR;
      off_latched <= 6'h00;
      fixed_port_mask <= DEFAULT_FIXED;
      charge_port_mask <= DEFAULT_CHARGE;
    end else begin
      state <= next_state;
      pll_run <= 1'b1;
      start_q <= (state == st_init) && (next_state == st_rom_check);
      if (next_state == st_rom_check) rom_pins_oe <= 1'b1;
      if (job.done) begin
        rom_pins_oe <= 1'b0;
        ext_rom_enable <= job.match;
      end
      if (state == st_cfg_read) settle_cnt <= settle_cnt + 6'h01;
      if (state == st_cfg_read && settled) begin
        off_latched <= dec_off;
        fixed_port_mask <= dec_fixed;
        charge_port_mask <= dec_charge;
      end
    end
  end

  // Port and status outputs, ports live only once boot is complete
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_enable <= 6'h00;
      ss_port_enable <= 6'h00;
      host_cfg_active <= 1'b0;
      config_done <= 1'b0;
    end else begin
      port_enable <= (next_state == st_ready) ? ~off_latched : 6'h00;
      ss_port_enable <= (next_state == st_ready) ? ~off_latched : 6'h00;
      host_cfg_active <= (next_state == st_host_cfg);
      config_done <= (next_state == st_ready);
    end
  end

  // AXI4-Lite write: address and data accepted in either order
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_gp = do_write && enumerated && w_lane0;
  wire wr_known = (aw_addr == `HB_REG_GP_DIR) || (aw_addr == `HB_REG_GP_OUT) ||
                  (aw_addr == `HB_REG_GP_PULL_EN) || (aw_addr == `HB_REG_GP_PULL_UP) ||
                  (aw_addr == `HB_REG_CFG_END) || (aw_addr == `HB_REG_STATUS) ||
                  (aw_addr == `HB_REG_STRAPS) || (aw_addr == `HB_REG_GP_IN);
  assign cfg_end_hit = do_write && (aw_addr == `HB_REG_CFG_END) && (state == st_host_cfg);
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `HB_RESP_OKAY : `HB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Pin direction, level and pull control, inputs float with no pulls
  logic [GP_W-1:0] gp_dir;
  logic [GP_W-1:0] gp_out;
  logic [GP_W-1:0] gp_pull_en;
  logic [GP_W-1:0] gp_pull_up;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gp_dir <= '0;
      gp_out <= '0;
      gp_pull_en <= '0;
      gp_pull_up <= '0;
    end else if (wr_gp) begin
      if (aw_addr == `HB_REG_GP_DIR) gp_dir <= w_data[GP_W-1:0];
      if (aw_addr == `HB_REG_GP_OUT) gp_out <= w_data[GP_W-1:0];
      if (aw_addr == `HB_REG_GP_PULL_EN) gp_pull_en <= w_data[GP_W-1:0];
      if (aw_addr == `HB_REG_GP_PULL_UP) gp_pull_up <= w_data[GP_W-1:0];
    end
  end

  // Registered pin drive; pulls only act on pins set as inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_purpose_pin_out <= '0;
      general_purpose_pin_oe <= '0;
      gp_pull_up_en <= '0;
      gp_pull_down_en <= '0;
    end else begin
      general_purpose_pin_out <= gp_out;
      general_purpose_pin_oe <= gp_dir;
      gp_pull_up_en <= ~gp_dir & gp_pull_en & gp_pull_up;
      gp_pull_down_en <= ~gp_dir & gp_pull_en & ~gp_pull_up;
    end
  end

  // AXI4-Lite read: one beat, answer the cycle after acceptance
  wire [11:0] ar_addr = {s_axi_araddr[11:2], 2'b00};
  wire [31:0] status_word = {19'h0, 3'(state), s_lock, ext_rom_enable,
                             host_cfg_active, config_done, 4'h0, pll_run, 1'b0};
  wire [31:0] strap_word = {14'h0, off_latched, fixed_port_mask, charge_port_mask};
  logic [31:0] rd_mux;
  logic rd_known;
  always_comb begin
    rd_mux = 32'h0;
    rd_known = 1'b1;
    case (ar_addr)
      `HB_REG_STATUS: rd_mux = status_word;
      `HB_REG_STRAPS: rd_mux = strap_word;
      `HB_REG_GP_DIR: rd_mux = 32'(gp_dir);
      `HB_REG_GP_OUT: rd_mux = 32'(gp_out);
      `HB_REG_GP_PULL_EN: rd_mux = 32'(gp_pull_en);
      `HB_REG_GP_PULL_UP: rd_mux = 32'(gp_pull_up);
      `HB_REG_GP_IN: rd_mux = 32'(s_gp_in);
      `HB_REG_CFG_END: rd_mux = 32'h0;
      default: rd_known = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `HB_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_known ? `HB_RESP_OKAY : `HB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : hub_boot_strap_sequencer

// *** bench/hub_boot_strap_sequencer_chk.sv ***
`timescale 1ns/100ps
`include "hub_boot_params.svh"
module hub_boot_strap_sequencer_chk #(
  parameter int GP_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Straps
  input wire logic rom_clock_mode3,
  input wire logic [2:0] slave_bus_setting,
  input wire logic mgmt_bus_data_pin,
  input wire logic mgmt_bus_clock_pin,
  // Serial ROM
  input wire logic rom_sclk,
  input wire logic rom_cs_n,
  input wire logic rom_pins_oe,
  // General-purpose pins
  input wire logic [GP_W-1:0] general_purpose_pin_oe,
  input wire logic [GP_W-1:0] gp_pull_up_en,
  input wire logic [GP_W-1:0] gp_pull_down_en,
  // Status
  input wire logic pll_run,
  input wire logic [23:0] exec_start_addr,
  input wire logic host_cfg_active,
  input wire logic config_done,
  input wire logic [5:0] port_enable,
  input wire logic [5:0] ss_port_enable,
  input wire logic [5:0] fixed_port_mask,
  input wire logic [5:0] charge_port_mask
);
  // One clock domain
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Probe frame start and its idle clock level
  sequence probe_open;
    $fell(rom_cs_n);
  endsequence
  sequence probe_idle;
    !rom_cs_n && rom_pins_oe && rom_sclk == rom_clock_mode3;
  endsequence

  AST_STANDBY: assert property (disable iff (1'b0)
    !aresetn |=> !pll_run && port_enable == 6'h00 && ss_port_enable == 6'h00 && !rom_pins_oe
      && !config_done && !host_cfg_active && general_purpose_pin_oe == '0)
    else $error("standby outputs not cleared");
  AST_PLL_START: assert property ($rose(aresetn) |=> pll_run)
    else $error("pll not running after release");
  AST_SS_FOLLOW: assert property (ss_port_enable == port_enable)
    else $error("superspeed side differs from legacy side");
  AST_PORTS_LATE: assert property (!config_done |-> port_enable == 6'h00)
    else $error("port enabled before boot finished");
  AST_EXEC_ZERO: assert property (exec_start_addr == 24'h000000)
    else $error("execution start address not zero");
  AST_HOST_EXCL: assert property (host_cfg_active |-> !config_done)
    else $error("boot finished while host stage active");
  AST_HOST_ROUTE: assert property ($rose(host_cfg_active) |->
    slave_bus_setting == `HB_LVL_200K_PU && mgmt_bus_data_pin && mgmt_bus_clock_pin)
    else $error("host stage entered without slave setting and pull-ups");
  AST_MASK_HOLD: assert property (config_done && $past(config_done) |->
    $stable(fixed_port_mask) && $stable(charge_port_mask) && $stable(port_enable))
    else $error("latched strap decode changed");
  AST_PROBE_MODE: assert property (probe_open |=> probe_idle [*2])
    else $error("probe clock not at mode idle level");
  AST_PULL_SANE: assert property ((gp_pull_up_en & gp_pull_down_en) == '0
    && ((gp_pull_up_en | gp_pull_down_en) & general_purpose_pin_oe) == '0)
    else $error("pull enable conflict");
endmodule : hub_boot_strap_sequencer_chk

bind hub_boot_strap_sequencer hub_boot_strap_sequencer_chk #(.GP_W(GP_W)) i_chk (
  .aclk, .aresetn, .rom_clock_mode3, .slave_bus_setting, .mgmt_bus_data_pin,
  .mgmt_bus_clock_pin, .rom_sclk, .rom_cs_n, .rom_pins_oe, .general_purpose_pin_oe,
  .gp_pull_up_en, .gp_pull_down_en, .pll_run, .exec_start_addr, .host_cfg_active,
  .config_done, .port_enable, .ss_port_enable, .fixed_port_mask, .charge_port_mask
);

// *** bench/serial_rom_model.sv ***
`timescale 1ns/100ps
`include "hub_boot_params.svh"
module serial_rom_model (
  // Serial ROM pins
  input wire logic rom_sclk,
  input wire logic rom_cs_n,
  input wire logic rom_mosi,
  output logic rom_miso,
  // High when the part holds a valid image
  input wire logic image_ok
);
  logic [31:0] req;
  logic [31:0] word;
  int cnt;
  // Image word at the probe address, ASCII 2DFU; 24-bit address space
  assign word = (req == {`HB_ROM_READ_CMD, `HB_ROM_SIG_ADDR} && image_ok) ?
    32'h32444655 : 32'h00FF00FF;
  initial begin
    cnt = 0;
    req = '0;
    rom_miso = 1'b0;
  end
  // Command and address on rising clock, mode 0 and mode 3 alike
  always @(posedge rom_sclk) begin
    if (!rom_cs_n) begin
      if (cnt < 32) req <= {req[30:0], rom_mosi};
      cnt <= cnt + 1;
    end
  end
  // Data out on falling clock, MSB first
  always @(negedge rom_sclk) begin
    if (!rom_cs_n && cnt >= 32 && cnt < 64) rom_miso <= word[63 - cnt];
  end
  // Released line shows the inverse of the last bit
  always @(posedge rom_cs_n) begin
    cnt <= 0;
    rom_miso <= ~rom_miso;
  end
endmodule : serial_rom_model

// *** bench/hub_boot_strap_sequencer_tb.sv ***
`timescale 1ns/100ps
`include "hub_boot_params.svh"
module hub_boot_strap_sequencer_tb;
  import hub_boot_pkg::*;
  localparam int GP_W = 8;
  logic aclk, aresetn, image_ok, pll_locked, rom_pins_oe, pll_run, ext_rom_enable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, host_cfg_active, config_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic rom_mode_strap, rom_clock_mode3, mgmt_bus_data_pin, mgmt_bus_clock_pin;
  logic [2:0] slave_bus_setting, fixed_port_select_strap, charge_port_select_strap;
  logic [5:0] port_plus_line_disable, port_minus_line_disable, port_enable, ss_port_enable;
  logic [5:0] fixed_port_mask, charge_port_mask;
  logic rom_miso, rom_sclk, rom_cs_n, rom_mosi;
  logic [23:0] exec_start_addr;
  logic [GP_W-1:0] general_purpose_pin_in, general_purpose_pin_out, general_purpose_pin_oe;
  logic [GP_W-1:0] gp_pull_up_en, gp_pull_down_en;
  int num_errors, n_tests;
  logic [5:0] mask_tab [6] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h3F};
  logic [11:0] gp_addr [4] = '{`HB_REG_GP_DIR, `HB_REG_GP_OUT, `HB_REG_GP_PULL_EN,
    `HB_REG_GP_PULL_UP};
  logic [7:0] gp_val [4] = '{8'h0F, 8'h05, 8'hF0, 8'h30};

  hub_boot_strap_sequencer #(.GP_W(GP_W)) i_hub_boot_strap_sequencer (.*);
  serial_rom_model i_serial_rom_model (.*);

  // Clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Verdict
  task final_report;
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Compare a value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Compare a bus response
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  // Bounded wait for a stage flag
  task automatic wait_flag(input int sel);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge aclk);
      if (sel == 0 && (config_done || host_cfg_active)) break;
      if (sel == 1 && config_done) break;
    end
    if (n == 3000) begin
      num_errors++;
      final_report();
    end
  endtask : wait_flag

  // Reset, then boot until a stage is reached
  task automatic boot;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_flag(0);
  endtask : boot

  // Bus write: address and data offered together, each released when taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) begin
      num_errors++;
      final_report();
    end
  endtask : axi_write

  // Bus read
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) begin
      num_errors++;
      final_report();
    end
  endtask : axi_read

  // Main sequence
  initial begin
    num_errors = 0;
    n_tests = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    pll_locked = 1'b1;
    general_purpose_pin_in = 8'hA5;
    {rom_mode_strap, rom_clock_mode3, mgmt_bus_data_pin, mgmt_bus_clock_pin} = 4'hB;
    image_ok = 1'b1;
    slave_bus_setting = `HB_LVL_200K_PU;
    port_plus_line_disable = 6'h2D;
    port_minus_line_disable = 6'h26;
    fixed_port_select_strap = `HB_LVL_10K_PU;
    charge_port_select_strap = `HB_LVL_10R_PU;
    // ROM image found, slave setting with both pull-ups: host stage
    boot();
    chk(host_cfg_active, 1'b1);
    chk(ext_rom_enable, 1'b1);
    for (int i = 0; i < 4; i++) begin
      axi_write(gp_addr[i], {24'h0, gp_val[i]}, resp);
      chk_resp(resp, `HB_RESP_OKAY);
      axi_read(gp_addr[i], rd, resp);
      chk(rd, {24'h0, gp_val[i]});
    end
    chk(general_purpose_pin_oe, 8'h0F);
    chk(general_purpose_pin_out & 8'h0F, 8'h05);
    chk(gp_pull_up_en, 8'h30);
    chk(gp_pull_down_en, 8'hC0);
    axi_read(`HB_REG_GP_IN, rd, resp);
    chk(rd, 32'h000000A5);
    axi_read(12'h020, rd, resp);
    chk_resp(resp, `HB_RESP_SLVERR);
    axi_write(12'h020, 32'h0000FFFF, resp);
    chk_resp(resp, `HB_RESP_SLVERR);
    axi_write(`HB_REG_CFG_END, 32'h00000001, resp);
    wait_flag(1);
    chk(host_cfg_active, 1'b0);
    chk(port_enable, 6'h1B);
    chk(ss_port_enable, 6'h1B);
    chk(fixed_port_mask, 6'h07);
    chk(charge_port_mask, 6'h3F);
    axi_read(`HB_REG_STRAPS, rd, resp);
    chk(rd, 32'h000241FF);
    port_plus_line_disable <= 6'h3F;
    fixed_port_select_strap <= `HB_LVL_200K_PD;
    repeat (8) @(posedge aclk);
    chk(port_enable, 6'h1B);
    chk(fixed_port_mask, 6'h07);
    // Standby in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({pll_run, rom_pins_oe, port_enable, general_purpose_pin_oe}, 32'h0);
    // Internal ROM path over all six strap levels
    port_plus_line_disable <= 6'h00;
    rom_mode_strap <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      slave_bus_setting <= (i == 2) ? `HB_LVL_200K_PU : 3'(i + 2);
      mgmt_bus_clock_pin <= (i == 2) ? 1'b0 : 1'b1;
      fixed_port_select_strap <= 3'(i);
      charge_port_select_strap <= 3'(5 - i);
      boot();
      chk({host_cfg_active, config_done, ext_rom_enable}, 3'b010);
      chk(fixed_port_mask, mask_tab[i]);
      chk(charge_port_mask, mask_tab[5 - i]);
      chk(port_enable, 6'h3F);
      axi_read(`HB_REG_GP_DIR, rd, resp);
      chk(rd, 32'h0);
    end
    // Mode 3 ROM, valid image then a blank one
    rom_mode_strap <= 1'b1;
    rom_clock_mode3 <= 1'b1;
    slave_bus_setting <= `HB_LVL_200K_PD;
    for (int k = 0; k < 2; k++) begin
      image_ok <= (k == 0);
      boot();
      chk(ext_rom_enable, (k == 0));
      chk(config_done, 1'b1);
    end
    final_report();
  end
endmodule : hub_boot_strap_sequencer_tb
